// ---- bmc_squelch_idle_timing.sv ----
`timescale 1ns/1ps
`include "bmc_timing_cfg.svh"
module bmc_squelch_idle_timing
  import bmc_timing_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // receive line and pulse limits from the decoder
  input  wire logic        rx_line,
  input  wire logic [7:0]  rx_hi_pulse_max,
  input  wire logic [7:0]  rx_lo_pulse_max,
  output logic             squelch,
  output logic             line_idle,
  // transmit bit timing
  input  wire logic        tx_bit_run,
  output logic             tx_bit_tick,
  // self-test control
  output logic             selftest_rx_enable,
  output logic             selftest_rx_clear,
  output logic             selftest_enable,
  output logic [2:0]       selftest_tx_mode
);

  // registers reachable by software
  logic [7:0]            squelch_assert_window;
  logic [7:0]            squelch_hold_window;
  logic [7:0]            tx_bit_period_value;
  logic [7:0]            idle_transition_window;
  logic [`ST_CTL_W-1:0]  selftest_control_a;

  // ahb data phase state
  logic                  dp_valid;
  logic                  dp_write;
  logic [13:0]           dp_idx;
  logic                  wrote_any;

  // line sampling
  logic                  rx_meta;
  logic                  rx_sync;
  logic                  rx_prev;
  logic [8:0]            run_cnt;

  // squelch and idle state
  squelch_state_t        state;
  squelch_state_t        next_state;
  logic [9:0]            hold_cnt;
  logic                  line_active;

  function automatic logic is_rw(input logic [13:0] idx);
    is_rw = (idx == `IDX_SQL_ASSERT) || (idx == `IDX_SQL_HOLD) || (idx == `IDX_TX_PERIOD) ||
            (idx == `IDX_IDLE_WIN) || (idx == `IDX_ST_CTL_A);
  endfunction

  // address phase decode; the slave never stalls, so hreadyout stays high
  wire        addr_take = hsel && htrans[1] && hready;
  wire [13:0] rd_idx    = haddr[15:2];
  wire        wr_en     = dp_valid && dp_write;
  wire [7:0]  wbyte     = hwdata[7:0];
  wire        wr_asrt   = wr_en && (dp_idx == `IDX_SQL_ASSERT);
  wire        wr_hold   = wr_en && (dp_idx == `IDX_SQL_HOLD);
  wire        wr_txp    = wr_en && (dp_idx == `IDX_TX_PERIOD);
  wire        wr_idle   = wr_en && (dp_idx == `IDX_IDLE_WIN);
  wire        wr_ctl    = wr_en && (dp_idx == `IDX_ST_CTL_A);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // read selection; a write still in its data phase is forwarded so a
  // back-to-back read of the same register never returns the stale value
  wire [7:0]  ctl_byte   = {{(8-`ST_CTL_W){1'b0}}, selftest_control_a};
  wire [7:0]  stat_byte  = {6'h00, line_active, squelch};
  wire [7:0]  reg_byte   = (rd_idx == `IDX_SQL_ASSERT) ? squelch_assert_window :
                           (rd_idx == `IDX_SQL_HOLD)   ? squelch_hold_window :
                           (rd_idx == `IDX_TX_PERIOD)  ? tx_bit_period_value :
                           (rd_idx == `IDX_IDLE_WIN)   ? idle_transition_window :
                           (rd_idx == `IDX_ST_CTL_A)   ? ctl_byte :
                           (rd_idx == `IDX_STATUS)     ? stat_byte : 8'h00;
  wire        bypass     = wr_en && (dp_idx == rd_idx) && is_rw(rd_idx);
  wire [7:0]  fwd_byte   = (rd_idx == `IDX_ST_CTL_A) ? {3'h0, wbyte[`ST_CTL_W-1:0]} : wbyte;
  wire [7:0]  rd_byte    = bypass ? fwd_byte : reg_byte;

  // address phase capture
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx   <= 14'h0000;
    end else if (hready) begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_idx   <= rd_idx;
    end
  end

  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // timing settings, all zero after reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      squelch_assert_window  <= `TIMING_RST;
      squelch_hold_window    <= `TIMING_RST;
      tx_bit_period_value    <= `TIMING_RST;
      idle_transition_window <= `TIMING_RST;
      selftest_control_a     <= `ST_CTL_RST;
    end else begin
      if (wr_asrt) squelch_assert_window  <= wbyte;
      if (wr_hold) squelch_hold_window    <= wbyte;
      if (wr_txp)  tx_bit_period_value    <= wbyte;
      if (wr_idle) idle_transition_window <= wbyte;
      if (wr_ctl)  selftest_control_a     <= wbyte[`ST_CTL_W-1:0];
    end
  end

  // a 0 to 1 write of the receiver enable resets prbs checker and counts
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      selftest_rx_clear <= 1'b0;
      wrote_any         <= 1'b0;
    end else begin
      selftest_rx_clear <= wr_ctl && wbyte[`ST_RX_EN_BIT] && !selftest_control_a[`ST_RX_EN_BIT];
      wrote_any         <= wrote_any || wr_en;
    end
  end

  assign selftest_rx_enable = selftest_control_a[`ST_RX_EN_BIT];
  assign selftest_enable    = selftest_control_a[`ST_EN_BIT];
  assign selftest_tx_mode   = selftest_control_a[2:0];

  // two flops before the line is looked at; rx_prev gives the edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_prev <= 1'b0;
    end else begin
      rx_meta <= rx_line;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  wire       rx_edge   = rx_sync ^ rx_prev;
  wire [7:0] pulse_max = rx_sync ? rx_hi_pulse_max : rx_lo_pulse_max;
  wire       too_long  = run_cnt > {1'b0, pulse_max};

  // pulse length since the last edge, saturating so a stuck line stays too long
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= 9'h000;
    end else begin
      run_cnt <= rx_edge ? 9'h000 : (&run_cnt ? run_cnt : run_cnt + 9'h001);
    end
  end

  // window lengths: squelch windows add one clock, idle window is exact
  wire [9:0] asrt_len = win_len(squelch_assert_window, 1'b1);
  wire [9:0] hold_len = win_len(squelch_hold_window, 1'b1);
  wire [9:0] idle_len = win_len(idle_transition_window, 1'b0);
  wire       sq_hit;
  wire       idle_hit;
  wire       idle_miss;

  // squelch window opens on an edge, so it slides along the line
  edge_window_detect #(
    .LEN_W    (10),
    .FREE_RUN (1'b0)
  ) u_squelch_window (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .edge_in    (rx_edge),
    .win_length (asrt_len),
    .hit        (sq_hit),
    .miss       ()
  );

  // idle window runs back to back so a silent line still times out
  edge_window_detect #(
    .LEN_W    (10),
    .FREE_RUN (1'b1)
  ) u_idle_window (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .edge_in    (rx_edge),
    .win_length (idle_len),
    .hit        (idle_hit),
    .miss       (idle_miss)
  );

  wire hold_done = hold_cnt >= (hold_len - 10'h001);

  // squelch sequencing
  always_comb begin
    next_state = state;
    case (state)
      SQ_OFF:  if (sq_hit) next_state = SQ_ON;
      SQ_ON:   if (too_long) next_state = SQ_HOLD;
      SQ_HOLD: begin
        if (rx_edge) next_state = SQ_ON;
        else if (hold_done) next_state = SQ_OFF;
      end
      default: next_state = SQ_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= SQ_OFF;
      squelch  <= 1'b0;
      hold_cnt <= 10'h000;
    end else begin
      state    <= next_state;
      squelch  <= next_state != SQ_OFF;
      hold_cnt <= (state == SQ_HOLD && next_state == SQ_HOLD) ? hold_cnt + 10'h001 : 10'h000;
    end
  end

  // line activity from the transition window
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_active <= 1'b0;
    end else if (idle_hit) begin
      line_active <= 1'b1;
    end else if (idle_miss) begin
      line_active <= 1'b0;
    end
  end

  assign line_idle = !line_active;

  bmc_tx_bit_timer #(
    .CNT_W (8)
  ) u_tx_bit_timer (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (tx_bit_run),
    .period   (tx_bit_period_value),
    .tick     (tx_bit_tick)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence rx_en_set_s;
    wr_ctl && wbyte[`ST_RX_EN_BIT] && !selftest_rx_enable;
  endsequence
  sequence rx_clear_s;
    selftest_rx_clear && selftest_rx_enable;
  endsequence

  squelch_assert_a: assert property (state == SQ_OFF && sq_hit |=> squelch)
    else $error("squelch not raised after three edges");
  squelch_drop_a: assert property (state == SQ_ON && too_long |=> state == SQ_HOLD && squelch)
    else $error("overlong pulse did not start hold");
  squelch_hold_a: assert property ($fell(squelch) |-> $past(hold_cnt) == hold_len - 10'h001)
    else $error("squelch dropped before hold window ended");
  hold_keeps_a: assert property (state == SQ_HOLD && !hold_done |=> squelch)
    else $error("squelch lost inside hold window");
  idle_declare_a: assert property (idle_miss && !idle_hit |=> line_idle)
    else $error("idle not declared after empty window");
  line_active_a: assert property (idle_hit |=> !line_idle)
    else $error("line not active after three transitions");
  selftest_clear_a: assert property (rx_en_set_s |=> rx_clear_s ##1 !selftest_rx_clear)
    else $error("self-test clear pulse missing or too long");
  timing_reset_a: assert property (!wrote_any |-> squelch_assert_window == 8'h00 &&
                                   squelch_hold_window == 8'h00 && tx_bit_period_value == 8'h00 &&
                                   idle_transition_window == 8'h00)
    else $error("timing setting not zero after reset");

endmodule // bmc_squelch_idle_timing

// ---- bmc_timing_cfg.svh ----
`ifndef BMC_TIMING_CFG_SVH
`define BMC_TIMING_CFG_SVH

// register indices, byte address is four times the index
`define IDX_SQL_ASSERT  14'h1aa8
`define IDX_SQL_HOLD    14'h1aa9
`define IDX_TX_PERIOD   14'h1ab0
`define IDX_IDLE_WIN    14'h1ab1
`define IDX_STATUS      14'h1ab2
`define IDX_ST_CTL_A    14'h1ac0

// reset values and field layout
`define TIMING_RST      8'h00
`define ST_CTL_RST      5'h00
`define ST_CTL_W        5
`define ST_RX_EN_BIT    4
`define ST_EN_BIT       3
`define STAT_SQL_BIT    0
`define STAT_ACT_BIT    1

// timing
`define WIN_UNIT        4
`define EDGE_TARGET     2'h3

`endif

// ---- bmc_timing_pkg.sv ----
package bmc_timing_pkg;

  // gray coded along off -> on -> hold
  typedef enum logic [1:0] {
    SQ_OFF  = 2'b00,
    SQ_ON   = 2'b01,
    SQ_HOLD = 2'b11
  } squelch_state_t;

  // window length in clocks from an 8-bit setting in units of four
  function automatic logic [9:0] win_len(input logic [7:0] setting, input logic add_one);
    win_len = {setting, 2'b00} + {9'h000, add_one};
  endfunction

endpackage

// ---- bmc_tx_bit_timer.sv ----
`timescale 1ns/1ps
module bmc_tx_bit_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] period,
  output logic                  tick
);

  if (CNT_W < 8) begin : g_bad_width
    $error("bmc_tx_bit_timer: CNT_W must hold an 8-bit count");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W:0]   gap;
  logic             had_tick;

  assign tick = run && (cnt == period);

  // count 0..period, so one bit lasts period+1 clocks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else begin
      cnt <= (!run || tick) ? '0 : cnt + CNT_W'(1);
    end
  end

  // helper: clocks since the previous tick while running
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap      <= '0;
      had_tick <= 1'b0;
    end else begin
      gap      <= (tick || !run) ? '0 : gap + (CNT_W+1)'(1);
      had_tick <= run && (tick || had_tick);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  bit_period_a: assert property (tick && had_tick && $stable(period) |-> gap == {1'b0, period})
    else $error("transmit bit period is not count plus one");

endmodule // bmc_tx_bit_timer

// ---- cc_line_partner.sv ----
`timescale 1ns/1ps
// far-side port partner: toggles the cc line every half_period clocks
module cc_line_partner (
  input  wire logic       core_clk,
  input  wire logic       active,
  input  wire logic [7:0] half_period,
  output logic            rx_line
);
  logic [7:0] cnt;

  // line rests at its last level between bursts, as a bmc line does
  initial begin
    rx_line = 1'b0;
    cnt     = 8'h00;
  end

  // counter restarts when idle so the first edge comes a full half period later
  always @(posedge core_clk) begin
    if (!active || cnt >= half_period - 8'h01) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
    if (active && cnt >= half_period - 8'h01) begin
      rx_line <= ~rx_line;
    end
  end
endmodule // cc_line_partner

// ---- edge_window_detect.sv ----
`timescale 1ns/1ps
`include "bmc_timing_cfg.svh"
module edge_window_detect
  import bmc_timing_pkg::*;
#(
  parameter int LEN_W    = 10,
  parameter bit FREE_RUN = 1'b0
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             edge_in,
  input  wire logic [LEN_W-1:0] win_length,
  output logic                  hit,
  output logic                  miss
);

  if (LEN_W < 10) begin : g_bad_width
    $error("edge_window_detect: LEN_W too small for an 8-bit setting times 4 plus 1");
  end

  logic [LEN_W-1:0] timer;
  logic [1:0]       edge_cnt;

  // armed windows start on the first edge; free windows always run
  wire              running  = FREE_RUN || (edge_cnt != 2'h0);
  wire [LEN_W-1:0]  last_cnt = (win_length == '0) ? '0 : win_length - LEN_W'(1);
  wire              win_end  = running && (timer >= last_cnt);
  // an edge on the arming or boundary clock is the window's first clock, so the
  // timer starts at one there; starting at zero would stretch the window a clock
  wire              seed     = edge_in && !hit;

  assign hit  = edge_in && (edge_cnt == (`EDGE_TARGET - 2'h1));
  assign miss = win_end && !hit;

  // restart on hit or window end; boundary edge seeds the next window
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer    <= '0;
      edge_cnt <= 2'h0;
    end else if (hit || win_end) begin
      timer    <= seed ? LEN_W'(1) : '0;
      edge_cnt <= seed ? 2'h1 : 2'h0;
    end else begin
      timer    <= running ? timer + LEN_W'(1) : (edge_in ? LEN_W'(1) : '0);
      edge_cnt <= edge_cnt + {1'b0, edge_in};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  three_edges_a: assert property (hit |-> edge_in && edge_cnt == 2'h2 && running)
    else $error("hit without three edges");
  window_restart_a: assert property (miss |=> edge_cnt <= 2'h1 && timer == LEN_W'(edge_cnt))
    else $error("window did not restart after miss");

endmodule // edge_window_detect

// ---- tb.sv ----
`timescale 1ns/1ps
`include "bmc_timing_cfg.svh"
module tb;
  localparam logic [31:0] A_ASSERT = {16'h0000, `IDX_SQL_ASSERT, 2'b00};
  localparam logic [31:0] A_HOLD   = {16'h0000, `IDX_SQL_HOLD, 2'b00};
  localparam logic [31:0] A_TX     = {16'h0000, `IDX_TX_PERIOD, 2'b00};
  localparam logic [31:0] A_IDLE   = {16'h0000, `IDX_IDLE_WIN, 2'b00};
  localparam logic [31:0] A_CTL    = {16'h0000, `IDX_ST_CTL_A, 2'b00};
  localparam logic [31:0] A_STAT   = {16'h0000, `IDX_STATUS, 2'b00};
  // status is read only, so its mask is zero and writes must not show
  localparam logic [31:0] ADDR [0:5] = '{A_ASSERT, A_HOLD, A_TX, A_IDLE, A_CTL, A_STAT};
  localparam logic [7:0]  MASK [0:5] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h00};

  logic        core_clk, arst_n, hsel, hwrite, tx_bit_run, active;
  logic [1:0]  htrans;
  logic [2:0]  hsize, st_mode;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic        hreadyout, hresp, squelch, line_idle, tx_bit_tick, rx_line;
  logic        st_rx_en, st_rx_clr, st_en;
  logic [7:0]  pulse_max, half_period, p;
  int          error_cnt, cmp_count, clr_seen, n, i, k;

  // 250 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  bmc_squelch_idle_timing u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_line(rx_line), .rx_hi_pulse_max(pulse_max),
    .rx_lo_pulse_max(pulse_max), .squelch(squelch), .line_idle(line_idle),
    .tx_bit_run(tx_bit_run), .tx_bit_tick(tx_bit_tick), .selftest_rx_enable(st_rx_en),
    .selftest_rx_clear(st_rx_clr), .selftest_enable(st_en), .selftest_tx_mode(st_mode)
  );

  cc_line_partner u_partner (
    .core_clk(core_clk), .active(active), .half_period(half_period), .rx_line(rx_line)
  );

  // count cycles with the clear pulse high; a stretched pulse counts twice
  always @(posedge core_clk) begin
    if (st_rx_clr === 1'b1) clr_seen++;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value %s expected %0d to %0d seen %0d", name, lo, hi, got);
    end
  endtask

  // expected read back: low byte through the register's writable mask
  function automatic logic [31:0] exp_reg(input int idx, input logic [31:0] wd);
    exp_reg = {24'h0, wd[7:0] & MASK[idx]};
  endfunction

  // a count of per gives one tick every per+1 clocks of run
  function automatic logic exp_tick(input int k, input logic [7:0] per);
    exp_tick = (k % (per + 1)) == 0;
  endfunction

  // single ahb-lite transfer; read data taken at the edge ending the data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_flag(input logic want, input bit sel_idle, input int lim, output int cyc);
    cyc = 0;
    while (((sel_idle ? line_idle : squelch) !== want) && cyc < lim) begin
      @(posedge core_clk);
      cyc++;
    end
  endtask

  task automatic hold_flag(input string name, input logic want, input bit sel_idle, input int cyc);
    repeat (cyc) begin
      @(posedge core_clk);
      check(name, {31'h0, want}, {31'h0, sel_idle ? line_idle : squelch});
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'ha1e38d59));
    {arst_n, hsel, hwrite, tx_bit_run, active} = 5'h00;
    {htrans, haddr, hwdata} = '0;
    hsize       = 3'b010;
    pulse_max   = 8'h1e;
    half_period = 8'h08;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    // reset values, then random write and read back
    for (i = 0; i < 6; i++) begin
      ahb(1'b0, ADDR[i], 32'h0);
      check("reset value", 32'h0, rd);
    end
    ahb(1'b0, 32'h00006ffc, 32'h0);
    check("unmapped", 32'h0, rd);
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 6; i++) begin
        d = $urandom;
        ahb(1'b1, ADDR[i], d);
        ahb(1'b0, ADDR[i], 32'h0);
        check("reg rw", exp_reg(i, d), rd);
      end
    end
    // recommended software settings
    ahb(1'b1, A_ASSERT, 32'd70);
    ahb(1'b1, A_HOLD, 32'd23);
    ahb(1'b1, A_TX, 32'd159);
    ahb(1'b1, A_IDLE, 32'd200);
    ahb(1'b0, A_TX, 32'h0);
    check("tx period", 32'd159, rd);
    ahb(1'b1, A_CTL, 32'h0);
    // bit timer: end and random periods, tick every period+1 clocks
    for (i = 0; i < 4; i++) begin
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom_range(1, 30));
      ahb(1'b1, A_TX, {24'h0, p});
      tx_bit_run <= 1'b1;
      for (k = 1; k <= 3 * (p + 1); k++) begin
        @(posedge core_clk);
        check("tx_bit_tick", {31'h0, exp_tick(k, p)}, {31'h0, tx_bit_tick});
      end
      tx_bit_run <= 1'b0;
      @(posedge core_clk);
    end
    // squelch: assert window 17 clocks, hold 13 clocks
    pulse_max <= 8'($urandom_range(20, 40));
    ahb(1'b1, A_ASSERT, 32'h4);
    ahb(1'b1, A_HOLD, 32'h3);
    ahb(1'b1, A_IDLE, 32'h5);
    half_period <= 8'd20;
    active      <= 1'b1;
    hold_flag("squelch slow edges", 1'b0, 1'b0, 200);
    // edges 8 apart: third edge lands on the window's last clock
    half_period <= 8'd8;
    wait_flag(1'b1, 1'b0, 80, n);
    check_range("squelch rise", 1, 79, n);
    hold_flag("squelch steady", 1'b1, 1'b0, 100);
    @(rx_line);
    @(posedge core_clk);
    active <= 1'b0;
    wait_flag(1'b0, 1'b0, 200, n);
    check_range("squelch drop", pulse_max + 13, pulse_max + 24, n);
    // idle detect: window of exactly 20 clocks
    half_period <= 8'd5;
    active      <= 1'b1;
    wait_flag(1'b0, 1'b1, 60, n);
    check_range("line active", 1, 59, n);
    hold_flag("line busy", 1'b0, 1'b1, 100);
    // edges 10 apart never put 3 in 20 clocks; 21 clocks would
    half_period <= 8'd10;
    wait_flag(1'b1, 1'b1, 60, n);
    check_range("line idle", 1, 59, n);
    hold_flag("line stays idle", 1'b1, 1'b1, 200);
    active <= 1'b0;
    // self-test receiver enable and its one-shot clear
    n = clr_seen;
    ahb(1'b1, A_CTL, 32'h10);
    repeat (2) @(posedge core_clk);
    #1;
    check("clear pulses", 32'h1, clr_seen - n);
    check("rx enable", 32'h1, {31'h0, st_rx_en});
    ahb(1'b1, A_CTL, 32'h1a);
    repeat (2) @(posedge core_clk);
    #1;
    check("clear pulses", 32'h1, clr_seen - n);
    ahb(1'b1, A_CTL, 32'h0);
    ahb(1'b1, A_CTL, 32'h1a);
    repeat (2) @(posedge core_clk);
    #1;
    check("clear pulses", 32'h2, clr_seen - n);
    check("st fields", {28'h0, 1'b1, 3'h2}, {28'h0, st_en, st_mode});
    give_verdict();
  end
endmodule // tb
